/* design/smrw_defs.svh */
// Behaviour
// - Byte lane selects follow address timing
// - Byte write strobes mimic single write strobe
// - Cycle starts with width-aligned address
// - Read strobe: setup, pulse, then address hold
// - Read chip select has own timing
// - Read hold derived from cycle length
// - Timings kept per chip select, clock cycles
// - Zero setup/hold keeps read signals low
// - Read mode 1 samples at strobe rise
// - Read mode 0 samples at select rise
// - Write strobe: setup, pulse, then hold
// - Write chip select has own timing
// - Write hold derived from cycle length
// - Zero setup keeps write signals low
// - Write mode 1 drives data after strobe setup
// - Write mode 0 drives data after select setup
// - Setup, pulse and cycle registers per select
// - Setup code is 128*top plus low five
// - Pulse code is 256*top plus low six
// - Cycle code is 256*top two plus seven
`ifndef SMRW_DEFS_SVH
`define SMRW_DEFS_SVH

// Configuration word selectors
`define SMRW_SEL_SETUP 2'h0
`define SMRW_SEL_PULSE 2'h1
`define SMRW_SEL_CYCLE 2'h2
`define SMRW_SEL_MODE 2'h3

// Setup word field positions, 6 bits each
`define SMRW_SU_WR_STB 0
`define SMRW_SU_WR_CS 8
`define SMRW_SU_RD_STB 16
`define SMRW_SU_RD_CS 24

// Pulse word field positions, 7 bits each
`define SMRW_PU_WR_STB 0
`define SMRW_PU_WR_CS 8
`define SMRW_PU_RD_STB 16
`define SMRW_PU_RD_CS 24

// Cycle word field positions, 9 bits each
`define SMRW_CY_WR 0
`define SMRW_CY_RD 16

// Mode word bits
`define SMRW_MODE_RD_BIT 0
`define SMRW_MODE_WR_BIT 1
`define SMRW_MODE_BAT_BIT 4
`define SMRW_MODE_DBW_LSB 12

// Data bus width codes
`define SMRW_DBW_8 2'h0
`define SMRW_DBW_16 2'h1
`define SMRW_DBW_32 2'h2

// Reset values of the per-select words
`define SMRW_RST_SETUP 32'h01010101
`define SMRW_RST_PULSE 32'h01010101
`define SMRW_RST_CYCLE 32'h00030003
`define SMRW_RST_MODE 32'h00000003

`endif

/* design/smrw_pkg.sv */
package smrw_pkg;
  `include "smrw_defs.svh"

  // Access sequencer states, one-hot
  typedef enum logic [1:0] {
    SMRW_IDLE = 2'b01,
    SMRW_ACTIVE = 2'b10
  } smrw_state_e;

  // Which per-select word a configuration write targets
  typedef enum logic [1:0] {
    SMRW_CFG_SETUP = `SMRW_SEL_SETUP,
    SMRW_CFG_PULSE = `SMRW_SEL_PULSE,
    SMRW_CFG_CYCLE = `SMRW_SEL_CYCLE,
    SMRW_CFG_MODE = `SMRW_SEL_MODE
  } smrw_cfg_sel_e;
endpackage

/* design/smrw_timing_decode.sv */
`timescale 1ns/100ps
`default_nettype none
`include "smrw_defs.svh"
module smrw_timing_decode (
  input wire logic [31:0] setupWord,
  input wire logic [31:0] pulseWord,
  input wire logic [31:0] cycleWord,
  input wire logic isWrite,
  output logic [7:0] stbSetup,
  output logic [8:0] stbPulse,
  output logic [7:0] csSetup,
  output logic [8:0] csPulse,
  output logic [9:0] cycLen
);
  // Setup code: 128 x bit5 plus bits 4..0
  function automatic logic [7:0] decSetup(input logic [5:0] c);
    decSetup = {c[5], 2'h0, c[4:0]};
  endfunction

  // Pulse code: 256 x bit6 plus bits 5..0
  function automatic logic [8:0] decPulse(input logic [6:0] c);
    decPulse = {c[6], 2'h0, c[5:0]};
  endfunction

  // Cycle code: 256 x bits 8..7 plus bits 6..0
  function automatic logic [9:0] decCycle(input logic [8:0] c);
    decCycle = {c[8:7], 1'h0, c[6:0]};
  endfunction

  // Pick the field set of the access direction
  always_comb begin
    if (isWrite) begin
      stbSetup = decSetup(setupWord[`SMRW_SU_WR_STB +: 6]);
      csSetup = decSetup(setupWord[`SMRW_SU_WR_CS +: 6]);
      stbPulse = decPulse(pulseWord[`SMRW_PU_WR_STB +: 7]);
      csPulse = decPulse(pulseWord[`SMRW_PU_WR_CS +: 7]);
      cycLen = decCycle(cycleWord[`SMRW_CY_WR +: 9]);
    end else begin
      stbSetup = decSetup(setupWord[`SMRW_SU_RD_STB +: 6]);
      csSetup = decSetup(setupWord[`SMRW_SU_RD_CS +: 6]);
      stbPulse = decPulse(pulseWord[`SMRW_PU_RD_STB +: 7]);
      csPulse = decPulse(pulseWord[`SMRW_PU_RD_CS +: 7]);
      cycLen = decCycle(cycleWord[`SMRW_CY_RD +: 9]);
    end
  end
endmodule
`default_nettype wire

/* design/smrw_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "smrw_defs.svh"
module smrw_ctrl #(
  parameter int NUM_CS = 8,
  parameter int CS_W = 3
) (
  input wire logic core_clk,
  input wire logic rst,
  // Configuration write port
  input wire logic cfgWrEn,
  input wire logic [CS_W-1:0] cfgCs,
  input wire smrw_pkg::smrw_cfg_sel_e cfgSel,
  input wire logic [31:0] cfgWdata,
  // Access request
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [CS_W-1:0] reqCs,
  input wire logic [25:0] reqAddr,
  input wire logic [3:0] reqByteEn,
  input wire logic [31:0] reqWdata,
  // Read answer
  output logic rdValid,
  output logic [31:0] rdData,
  output logic busy,
  // External memory pins
  output logic [25:0] addrOut,
  output logic [NUM_CS-1:0] chipSelectN,
  output logic readStrobeN,
  output logic [3:0] byteLaneWriteN,
  output logic [3:0] byteLaneSelectN,
  output logic [31:0] dataOut,
  output logic dataOe,
  input wire logic [31:0] dataIn
);
  import smrw_pkg::*;

  // Per-select configuration words
  logic [31:0] setupCfg_q [NUM_CS];
  logic [31:0] pulseCfg_q [NUM_CS];
  logic [31:0] cycleCfg_q [NUM_CS];
  logic [31:0] modeCfg_q [NUM_CS];

  // Sequencer state and position in the cycle
  smrw_state_e state_q;
  logic [9:0] cnt_q;

  // Timing latched for the access in flight
  logic [7:0] stbSetup_q;
  logic [8:0] stbPulse_q;
  logic [7:0] csSetup_q;
  logic [8:0] csPulse_q;
  logic [9:0] cycLen_q;
  logic [31:0] mode_q;
  logic curWr_q;
  logic [CS_W-1:0] curCs_q;
  logic [3:0] byteEn_q;

  // Decoded timing of the requested select
  logic [7:0] newStbSetup;
  logic [8:0] newStbPulse;
  logic [7:0] newCsSetup;
  logic [8:0] newCsPulse;
  logic [9:0] newCycLen;

  // Values that the next edge will put in force
  logic [7:0] nxtStbSetup;
  logic [8:0] nxtStbPulse;
  logic [7:0] nxtCsSetup;
  logic [8:0] nxtCsPulse;
  logic [31:0] nxtMode;
  logic nxtWr;
  logic [CS_W-1:0] nxtCs;
  logic [3:0] nxtByteEn;
  logic [9:0] nxtCnt;
  logic nxtActive;

  // Handshake and window terms
  logic actState;
  logic lastCyc;
  logic start;
  logic stbOn;
  logic csOn;
  logic drvOn;
  logic [3:0] laneMask;
  logic [9:0] rdEnd;
  logic sampleNow;
  logic [1:0] nxtDbw;

  // Sequencer is busy while in the active state
  assign actState = (state_q == SMRW_ACTIVE);
  // Last cycle of the programmed length; a zero length acts as one
  assign lastCyc = ((cnt_q + 10'h001) >= cycLen_q);

  // Back-to-back only to the same select in the same direction,
  // so that zero setup and hold leave the strobes low throughout.
  // Any other change goes through one idle cycle with all pins high.
  assign reqReady = (state_q == SMRW_IDLE) |
                    (actState & lastCyc & (reqCs == curCs_q) &
                     (reqWrite == curWr_q));
  assign start = reqValid & reqReady;
  assign busy = actState;

  // One decoder serves the select being started
  smrw_timing_decode uDecode (
    .setupWord(setupCfg_q[reqCs]),
    .pulseWord(pulseCfg_q[reqCs]),
    .cycleWord(cycleCfg_q[reqCs]),
    .isWrite(reqWrite),
    .stbSetup(newStbSetup),
    .stbPulse(newStbPulse),
    .csSetup(newCsSetup),
    .csPulse(newCsPulse),
    .cycLen(newCycLen)
  );

  // Configuration words, one set per select
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Reset gives every select the default timing
      for (int i = 0; i < NUM_CS; i++) begin
        setupCfg_q[i] <= `SMRW_RST_SETUP;
        pulseCfg_q[i] <= `SMRW_RST_PULSE;
        cycleCfg_q[i] <= `SMRW_RST_CYCLE;
        modeCfg_q[i] <= `SMRW_RST_MODE;
      end
    end else if (cfgWrEn) begin
      // Word chosen by the selector
      if (cfgSel == SMRW_CFG_SETUP) begin
        setupCfg_q[cfgCs] <= cfgWdata;
      end else if (cfgSel == SMRW_CFG_PULSE) begin
        pulseCfg_q[cfgCs] <= cfgWdata;
      end else if (cfgSel == SMRW_CFG_CYCLE) begin
        cycleCfg_q[cfgCs] <= cfgWdata;
      end else begin
        // Mode word: read and write sources, lane type, width
        modeCfg_q[cfgCs] <= cfgWdata;
      end
    end
  end

  // Next-edge view: a new access or the one in flight
  always_comb begin
    // Pins and state both register from this view, so they move together
    nxtStbSetup = start ? newStbSetup : stbSetup_q;
    nxtStbPulse = start ? newStbPulse : stbPulse_q;
    nxtCsSetup = start ? newCsSetup : csSetup_q;
    nxtCsPulse = start ? newCsPulse : csPulse_q;
    nxtMode = start ? modeCfg_q[reqCs] : mode_q;
    nxtWr = start ? reqWrite : curWr_q;
    nxtCs = start ? reqCs : curCs_q;
    nxtByteEn = start ? reqByteEn : byteEn_q;
    // Counter restarts at zero on every take
    nxtCnt = start ? 10'h000 : (cnt_q + 10'h001);
    nxtActive = start | (actState & ~lastCyc);
    nxtDbw = nxtMode[`SMRW_MODE_DBW_LSB +: 2];
  end

  // Strobe, select and drive windows, counted from the address
  always_comb begin
    // Strobe low from setup for pulse cycles, then hold
    stbOn = nxtActive & (nxtCnt >= {2'h0, nxtStbSetup}) &
            (nxtCnt < ({2'h0, nxtStbSetup} + {1'h0, nxtStbPulse}));
    // Chip select on its own setup and pulse
    csOn = nxtActive & (nxtCnt >= {2'h0, nxtCsSetup}) &
           (nxtCnt < ({2'h0, nxtCsSetup} + {1'h0, nxtCsPulse}));
    // Data drive from the end of the chosen setup to cycle end
    if (nxtMode[`SMRW_MODE_WR_BIT]) begin
      drvOn = nxtActive & nxtWr & (nxtCnt >= {2'h0, nxtStbSetup});
    end else begin
      drvOn = nxtActive & nxtWr & (nxtCnt >= {2'h0, nxtCsSetup});
    end
  end

  // Lanes that exist on the configured bus width
  always_comb begin
    if (nxtDbw == `SMRW_DBW_32) begin
      // Four lanes on a 32-bit bus
      laneMask = 4'hf;
    end else if (nxtDbw == `SMRW_DBW_16) begin
      // Two lanes on a 16-bit bus
      laneMask = 4'h3;
    end else begin
      // One lane on an 8-bit bus
      laneMask = 4'h1;
    end
  end

  // Sequencer state and counter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= SMRW_IDLE;
      cnt_q <= 10'h000;
    end else begin
      // Counter also runs while idle; every pin term is gated by the active flag
      cnt_q <= nxtCnt;
      // Stay active while another access follows directly
      if (nxtActive) begin
        state_q <= SMRW_ACTIVE;
      end else begin
        state_q <= SMRW_IDLE;
      end
    end
  end

  // Timing latched at start; later config writes do not disturb it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Harmless defaults; nothing is driven before the first take
      stbSetup_q <= 8'h00;
      stbPulse_q <= 9'h001;
      csSetup_q <= 8'h00;
      csPulse_q <= 9'h001;
      cycLen_q <= 10'h001;
      mode_q <= `SMRW_RST_MODE;
      curWr_q <= 1'b0;
      curCs_q <= '0;
      byteEn_q <= 4'h0;
    end else if (start) begin
      stbSetup_q <= newStbSetup;
      stbPulse_q <= newStbPulse;
      csSetup_q <= newCsSetup;
      csPulse_q <= newCsPulse;
      cycLen_q <= newCycLen;
      mode_q <= modeCfg_q[reqCs];
      curWr_q <= reqWrite;
      curCs_q <= reqCs;
      byteEn_q <= reqByteEn;
    end
  end

  // Address bus: placed at cycle start, held through the cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addrOut <= 26'h0000000;
    end else if (start) begin
      // Unused low bits driven zero for wide devices
      if (nxtDbw == `SMRW_DBW_32) begin
        addrOut <= {reqAddr[25:2], 2'h0};
      end else if (nxtDbw == `SMRW_DBW_16) begin
        addrOut <= {reqAddr[25:1], 1'h0};
      end else begin
        // 8-bit devices use every address bit
        addrOut <= reqAddr;
      end
    end
  end

  // Chip selects: only the addressed line may go low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // All lines high in reset
      chipSelectN <= '1;
    end else begin
      for (int i = 0; i < NUM_CS; i++) begin
        // Line i is low only inside the select pulse of its own access
        chipSelectN[i] <= ~(csOn & (nxtCs == i[CS_W-1:0]));
      end
    end
  end

  // Read strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      readStrobeN <= 1'b1;
    end else begin
      // Low only inside the strobe window of a read
      readStrobeN <= ~(stbOn & ~nxtWr);
    end
  end

  // Write strobes: lane 0 doubles as the single write strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      byteLaneWriteN <= 4'hf;
    end else if (nxtMode[`SMRW_MODE_BAT_BIT] & (nxtDbw != `SMRW_DBW_8)) begin
      // Byte write: one strobe per enabled lane, same waveform
      byteLaneWriteN <= ~({4{stbOn & nxtWr}} & nxtByteEn & laneMask);
    end else begin
      // Byte select or 8-bit: single strobe on lane 0
      byteLaneWriteN <= {3'h7, ~(stbOn & nxtWr)};
    end
  end

  // Byte lane selects span the whole cycle, like the address
  always_ff @(posedge core_clk) begin
    if (rst) begin
      byteLaneSelectN <= 4'hf;
    end else if (~nxtMode[`SMRW_MODE_BAT_BIT] & (nxtDbw != `SMRW_DBW_8)) begin
      byteLaneSelectN <= ~({4{nxtActive}} & nxtByteEn & laneMask);
    end else begin
      // Unused in byte write mode and on 8-bit buses
      byteLaneSelectN <= 4'hf;
    end
  end

  // Write data and its drive enable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dataOut <= 32'h00000000;
      dataOe <= 1'b0;
    end else begin
      // Word taken at the start, so later request changes cannot disturb it
      if (start) begin
        dataOut <= reqWdata;
      end
      // Enable follows the setup window chosen by the write mode
      dataOe <= drvOn;
    end
  end

  // End of the controlling read pulse, relative to cycle start
  always_comb begin
    if (mode_q[`SMRW_MODE_RD_BIT]) begin
      // Strobe rise ends the read
      rdEnd = {2'h0, stbSetup_q} + {1'h0, stbPulse_q};
    end else begin
      // Select rise ends the read
      rdEnd = {2'h0, csSetup_q} + {1'h0, csPulse_q};
    end
  end

  // Sample on the edge that ends the controlling pulse. The data
  // lines are taken straight off the pins: the pulse timing itself
  // guarantees they are settled, and a synchroniser would move the
  // capture away from the strobe edge.
  assign sampleNow = actState & ~curWr_q & ((cnt_q + 10'h001) == rdEnd);

  // Read answer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdValid <= 1'b0;
      rdData <= 32'h00000000;
    end else begin
      // Valid for one cycle; data holds until the next capture
      rdValid <= sampleNow;
      if (sampleNow) begin
        rdData <= dataIn;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/smrw_ctrl_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module smrw_ctrl_sva #(
  parameter int NUM_CS = 8,
  parameter int CS_W = 3
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [25:0] reqAddr,
  input wire logic rdValid,
  input wire logic [31:0] rdData,
  input wire logic busy,
  input wire logic [25:0] addrOut,
  input wire logic [NUM_CS-1:0] chipSelectN,
  input wire logic readStrobeN,
  input wire logic [3:0] byteLaneWriteN,
  input wire logic [3:0] byteLaneSelectN,
  input wire logic [31:0] dataOut,
  input wire logic dataOe,
  input wire logic [31:0] dataIn
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Take edge; a new cycle may move the pins right after it
  wire logic took = reqValid && reqReady;
  idle_pins_a: assert property (
    !busy |-> (&chipSelectN) && readStrobeN && (&byteLaneWriteN) && !dataOe)
    else $error("control pins active while idle");
  one_select_a: assert property ($onehot0(~chipSelectN))
    else $error("more than one select low");
  rd_wr_excl_a: assert property (!readStrobeN |-> (&byteLaneWriteN) && !dataOe)
    else $error("read strobe overlaps a write");
  drive_in_cycle_a: assert property (dataOe |-> busy)
    else $error("data driven outside a cycle");
  sample_after_cycle_a: assert property (rdValid |-> $past(busy))
    else $error("read answer without a cycle");
  read_capture_a: assert property (rdValid |-> rdData == $past(dataIn))
    else $error("read data not taken from pins");
  take_launch_a: assert property (
    took |=> busy && addrOut[25:2] == $past(reqAddr[25:2]))
    else $error("address not set at take");
  addr_hold_a: assert property (
    busy && $past(busy) && !$past(took) |-> $stable(addrOut) && $stable(byteLaneSelectN))
    else $error("address moved inside a cycle");
  wdata_hold_a: assert property (
    dataOe && $past(dataOe) && !$past(took) |-> $stable(dataOut))
    else $error("write data moved while driven");
  rd_seen_c: cover property (rdValid);
  wr_seen_c: cover property ($rose(dataOe));
  chain_c: cover property (busy && took);
endmodule
bind smrw_ctrl smrw_ctrl_sva #(.NUM_CS(NUM_CS), .CS_W(CS_W)) u_sva (.core_clk(core_clk),
  .rst(rst), .reqValid(reqValid), .reqReady(reqReady), .reqAddr(reqAddr),
  .rdValid(rdValid), .rdData(rdData), .busy(busy), .addrOut(addrOut),
  .chipSelectN(chipSelectN), .readStrobeN(readStrobeN), .byteLaneWriteN(byteLaneWriteN),
  .byteLaneSelectN(byteLaneSelectN), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn));
`default_nettype wire

/* sim/smrw_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module smrw_mem_model (
  input wire logic core_clk,
  input wire logic [25:0] addrOut,
  input wire logic [7:0] chipSelectN,
  input wire logic readStrobeN,
  input wire logic [3:0] byteLaneWriteN,
  input wire logic [31:0] dataOut,
  input wire logic dataOe,
  output logic [31:0] dataIn
);
  // Sixteen words picked by the word address bits
  logic [31:0] mem [16];
  logic [31:0] lastQ = 32'h0;
  // Answers only while selected or strobed and the bus is not driven
  wire logic drv = (!readStrobeN || !(&chipSelectN)) && !dataOe;
  // Level store, so zero setup and hold writes are safe here
  always @(posedge core_clk) begin
    if (!(&byteLaneWriteN) && dataOe) mem[addrOut[5:2]] <= dataOut;
    if (drv) lastQ <= mem[addrOut[5:2]];
  end
  // Released bus shows the inverse word, so a late sample cannot match
  assign dataIn = drv ? mem[addrOut[5:2]] : ~lastQ;
endmodule
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import smrw_pkg::*;
  // One case: read codes; writes swap strobe and select codes
  typedef struct {
    logic [2:0] cs;
    logic [5:0] s;
    logic [5:0] c;
    logic [6:0] p;
    logic [6:0] q;
    logic [8:0] l;
    logic [31:0] mode;
    logic [3:0] be;
  } smrw_tc_s;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cfgWrEn = 1'b0;
  logic [2:0] cfgCs = 3'h0;
  smrw_cfg_sel_e cfgSel = SMRW_CFG_SETUP;
  logic [31:0] cfgWdata = 32'h0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [2:0] reqCs = 3'h0;
  logic [25:0] reqAddr = 26'h0;
  logic [3:0] reqByteEn = 4'hf;
  logic [31:0] reqWdata = 32'h0;
  logic reqReady, rdValid, busy, readStrobeN, dataOe;
  logic [31:0] rdData, dataOut;
  logic [25:0] addrOut;
  logic [7:0] chipSelectN;
  logic [3:0] byteLaneWriteN, byteLaneSelectN;
  wire logic [31:0] dataIn;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int t0, t1, nt, x;
  // Monitor tallies: strobe first/len, select first/len, drive first/len, busy, sample, reads
  int m[9];
  logic [31:0] rdl;
  logic [25:0] ad;
  logic [3:0] bls, wl;
  logic wrM;
  logic [2:0] csM;
  smrw_tc_s tc[4];
  always #5 core_clk = ~core_clk;
  smrw_ctrl u_dut (.core_clk(core_clk), .rst(rst), .cfgWrEn(cfgWrEn), .cfgCs(cfgCs),
    .cfgSel(cfgSel), .cfgWdata(cfgWdata), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .reqCs(reqCs), .reqAddr(reqAddr), .reqByteEn(reqByteEn),
    .reqWdata(reqWdata), .rdValid(rdValid), .rdData(rdData), .busy(busy),
    .addrOut(addrOut), .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
    .byteLaneWriteN(byteLaneWriteN), .byteLaneSelectN(byteLaneSelectN),
    .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn));
  smrw_mem_model u_mem (.core_clk(core_clk), .addrOut(addrOut), .chipSelectN(chipSelectN),
    .readStrobeN(readStrobeN), .byteLaneWriteN(byteLaneWriteN), .dataOut(dataOut),
    .dataOe(dataOe), .dataIn(dataIn));
  function automatic int dsu(input logic [5:0] v);
    return 128 * v[5] + v[4:0];
  endfunction
  function automatic int dpu(input logic [6:0] v);
    return 256 * v[6] + v[5:0];
  endfunction
  function automatic int dcy(input logic [8:0] v);
    return 256 * v[8:7] + v[6:0];
  endfunction
  function automatic logic [31:0] wd(input int k);
    return 32'ha5c30000 + 32'(k);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Pins seen before each edge belong to count cyc-t0-1; racing the take edge is avoided
  always @(posedge core_clk) begin
    cyc++;
    x = cyc - t0 - 1;
    if (nt > 0) begin
      if (busy === 1'b1) begin
        if (m[6] == 0) ad = addrOut;
        if (m[6] == 0) bls = byteLaneSelectN;
        m[6]++;
      end
      if ((wrM ? &byteLaneWriteN : readStrobeN) === 1'b0) begin
        if (m[1] == 0) m[0] = x;
        m[1]++;
        wl = byteLaneWriteN;
      end
      if (chipSelectN[csM] === 1'b0) begin
        if (m[3] == 0) m[2] = x;
        m[3]++;
      end
      if (dataOe === 1'b1) begin
        if (m[5] == 0) m[4] = x;
        m[5]++;
      end
      if (rdValid === 1'b1) begin
        if (m[8] == 0) m[7] = x;
        m[8]++;
        rdl = rdData;
      end
    end
    if (reqValid === 1'b1 && reqReady === 1'b1) begin
      if (nt == 0) m = '{default: 0};
      if (nt == 0) t0 = cyc;
      else t1 = cyc;
      nt++;
    end
    // Ceiling well above the longest sequence; a hang ends as a failure
    if (cyc > 20000) begin
      fails++;
      results();
    end
  end
  task automatic cfg(input logic [2:0] cs, input smrw_cfg_sel_e sel, input logic [31:0] d);
    @(posedge core_clk);
    cfgWrEn <= 1'b1;
    cfgCs <= cs;
    cfgSel <= sel;
    cfgWdata <= d;
    @(posedge core_clk);
    cfgWrEn <= 1'b0;
  endtask
  // n requests kept back to back; sw sends the second one to another select
  task automatic run(input int k, input logic wr, input int n, input logic sw);
    int s, p, c, q, l;
    logic [1:0] dbw;
    s = dsu(wr ? tc[k].c : tc[k].s);
    c = dsu(wr ? tc[k].s : tc[k].c);
    p = dpu(wr ? tc[k].q : tc[k].p);
    q = dpu(wr ? tc[k].p : tc[k].q);
    l = dcy(tc[k].l);
    dbw = tc[k].mode[13:12];
    nt = 0;
    wrM = wr;
    csM = tc[k].cs;
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqCs <= tc[k].cs;
    reqAddr <= 26'(k * 4 + 3);
    reqWdata <= wd(k);
    reqByteEn <= tc[k].be;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      while (reqReady !== 1'b1) @(posedge core_clk);
      reqCs <= sw ? 3'h0 : tc[k].cs;
      reqAddr <= 26'(k * 4 + 7);
      reqWdata <= ~wd(k);
      if (i == n - 1) reqValid <= 1'b0;
    end
    @(posedge core_clk);
    while (busy !== 1'b0) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    if (n == 2) chk("take spacing", !sw, t1 - t0 == l);
    if (!sw) begin
      chk("address", 26'(k * 4 + 3) & ~(dbw == 2 ? 26'h3 : 26'({dbw[0]})), ad);
      chk("strobe start", s, m[0]);
      chk("strobe width", n * p, m[1]);
      chk("select start", c, m[2]);
      chk("select width", n * q, m[3]);
      chk("cycle length", n * l, m[6]);
      chk("lane select", tc[k].mode[4] || dbw == 2'h0 ? 4'hf :
        4'(~(tc[k].be & (dbw == 2'h2 ? 4'hf : 4'h3))), bls);
      if (wr) begin
        chk("drive start", tc[k].mode[1] ? s : c, m[4]);
        chk("drive length", n * l - m[4], m[5]);
        chk("write lanes", tc[k].mode[4] ? 4'(~tc[k].be) : 4'he, wl);
      end else begin
        chk("sample point", tc[k].mode[0] ? s + p : c + q, m[7]);
        chk("read count", n, m[8]);
        chk("read data", n == 2 ? ~wd(k) : wd(k), rdl);
      end
    end
    $display("test %0d dir %0d count %0d done", k, wr, n);
  endtask
  initial begin
    tc[0] = '{3'h0, 6'h01, 6'h00, 7'h02, 7'h03, 9'h004, 32'h00000003, 4'hf};
    tc[1] = '{3'h3, 6'h02, 6'h01, 7'h01, 7'h03, 9'h005, 32'h00002000, 4'h5};
    tc[2] = '{3'h7, 6'h21, 6'h00, 7'h41, 7'h01, 9'h103, 32'h00002012, 4'h6};
    tc[3] = '{3'h5, 6'h00, 6'h00, 7'h02, 7'h02, 9'h002, 32'h00001003, 4'hf};
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk("idle selects", 8'hff, chipSelectN);
    chk("idle strobes", 9'h1ff, {readStrobeN, byteLaneWriteN, byteLaneSelectN});
    chk("idle handshake", 3'h4, {reqReady, rdValid, dataOe});
    // Each tested select programmed before any access; pulses nonzero, setup plus pulse within cycle
    for (int k = 0; k < 4; k++) begin
      cfg(tc[k].cs, SMRW_CFG_SETUP, {2'h0, tc[k].c, 2'h0, tc[k].s, 2'h0, tc[k].s,
        2'h0, tc[k].c});
      cfg(tc[k].cs, SMRW_CFG_PULSE, {1'h0, tc[k].q, 1'h0, tc[k].p, 1'h0, tc[k].p,
        1'h0, tc[k].q});
      cfg(tc[k].cs, SMRW_CFG_CYCLE, {7'h0, tc[k].l, 7'h0, tc[k].l});
      cfg(tc[k].cs, SMRW_CFG_MODE, tc[k].mode);
    end
    for (int k = 0; k < 4; k++) begin
      run(k, 1'b1, 1, 1'b0);
      run(k, 1'b0, 1, 1'b0);
    end
    run(3, 1'b1, 2, 1'b0);
    run(3, 1'b0, 2, 1'b0);
    run(3, 1'b0, 2, 1'b1);
    results();
  end
endmodule
`default_nettype wire
